// file: logic/arts_timer.sv
// split-mode auto-reload timer with an axi4-lite register slave.
// assumes one 250 mhz clock, a synchronous active-low reset, and asynchronous
// external-clock and low-frequency-oscillator pins.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "arts_defs.svh"

// How it works
// RQ1 - control bit 3 picks 16-bit or split
// RQ2 - 16-bit wrap reloads and sets high flag
// RQ3 - 16-bit overflow interrupts when timer enabled
// RQ4 - low-byte wrap interrupts when also enabled
// RQ5 - split bytes reload from own reload bytes
// RQ6 - run gates whole counter, or high only
// RQ7 - byte select: system, divided-12, external-8
// RQ8 - external clock synchronised before use
// RQ9 - byte wraps set high and low flags
// RQ10 - split: high overflow, optionally low, interrupt
// RQ11 - hardware never clears overflow flags
// RQ12 - oscillator fall captures count, interrupts
// RQ13 - control bit 1 reads zero
// RQ14 - low count read follows the mode; the code returns cnt_lo_reg as is in both modes
// RQ15 - low clock select drives 16-bit counter
// RQ16 - high clock select only in split
// RQ17 - interrupt holds while enabled flag set
// RQ18 - software count writes beat increments
module arts_timer #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // asynchronous pins
  input wire logic i_ext_clk,
  input wire logic i_lfo_clk,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // interrupt
  output logic o_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] ctrl_reg;
  logic hi_flag_reg;
  logic lo_flag_reg;
  logic cap_flag_reg;
  logic [2:0] mask_reg;
  logic gie_reg;
  logic [1:0] clkctl_reg;
  logic [7:0] rl_lo_reg;
  logic [7:0] rl_hi_reg;
  logic [7:0] cnt_lo_reg;
  logic [7:0] cnt_hi_reg;
  logic irq_reg;
  logic [3:0] div_sys_reg;
  logic [2:0] div_ext_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic lfo_s1_reg;
  logic lfo_s2_reg;
  logic lfo_s3_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire aw_take = i_awvalid & awready_reg;
  wire w_take = i_wvalid & wready_reg;
  wire ar_take = i_arvalid & arready_reg;
  wire wr_do = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire [9:0] wr_idx = aw_addr_reg[11:2];
  wire [9:0] rd_idx = i_araddr[11:2];
  wire wr_byte = wr_do & w_strb_reg;
  wire wr_ctrl = wr_byte & (wr_idx == `ARTS_IDX_CTRL);
  wire wr_rl_lo = wr_byte & (wr_idx == `ARTS_IDX_RL_LO);
  wire wr_rl_hi = wr_byte & (wr_idx == `ARTS_IDX_RL_HI);
  wire wr_cnt_lo = wr_byte & (wr_idx == `ARTS_IDX_CNT_LO);
  wire wr_cnt_hi = wr_byte & (wr_idx == `ARTS_IDX_CNT_HI);
  wire wr_clkctl = wr_byte & (wr_idx == `ARTS_IDX_CLKCTL);
  wire wr_gie = wr_byte & (wr_idx == `ARTS_IDX_GIE);
  wire wr_stat = wr_byte & (wr_idx == `ARTS_IDX_STAT);
  wire wr_mask = wr_byte & (wr_idx == `ARTS_IDX_MASK);
  wire wr_hit = wr_ctrl | wr_rl_lo | wr_rl_hi | wr_cnt_lo | wr_cnt_hi |
                wr_clkctl | wr_gie | wr_stat | wr_mask;
  // a write with the low lane off still needs a known address to be okay
  wire wr_mapped = (wr_idx == `ARTS_IDX_CTRL) | (wr_idx == `ARTS_IDX_RL_LO) |
                   (wr_idx == `ARTS_IDX_RL_HI) | (wr_idx == `ARTS_IDX_CNT_LO) |
                   (wr_idx == `ARTS_IDX_CNT_HI) | (wr_idx == `ARTS_IDX_CLKCTL) |
                   (wr_idx == `ARTS_IDX_GIE) | (wr_idx == `ARTS_IDX_STAT) |
                   (wr_idx == `ARTS_IDX_MASK) | wr_hit;

  // ****************************************************************
  // mode and clock sources
  // ****************************************************************
  wire split = ctrl_reg[`ARTS_CTRL_SPLIT];
  wire run = ctrl_reg[`ARTS_CTRL_RUN];
  arts_pkg::arts_mode_t mode;
  assign mode = split ? arts_pkg::ARTS_SPLIT : arts_pkg::ARTS_MODE16; // RQ1

  // edge detectors read only the second and third stages
  wire ext_rise = ext_s2_reg & ~ext_s3_reg; // RQ8
  wire lfo_fall = ~lfo_s2_reg & lfo_s3_reg;
  wire tick_sys12 = (div_sys_reg == `ARTS_DIV_SYS);
  wire tick_ext8 = ext_rise & (div_ext_reg == `ARTS_DIV_EXT);
  wire tick_alt = ctrl_reg[`ARTS_CTRL_EXT_SEL] ? tick_ext8 : tick_sys12; // RQ7
  wire tick_lo = clkctl_reg[0] | tick_alt; // RQ15
  wire tick_hi = clkctl_reg[1] | tick_alt; // RQ16

  // ****************************************************************
  // counter next value
  // ****************************************************************
  wire [15:0] cnt16 = {cnt_hi_reg, cnt_lo_reg};
  wire [15:0] cnt16_inc = cnt16 + 16'h0001;
  wire [7:0] lo_inc = cnt_lo_reg + 8'h01;
  wire [7:0] hi_inc = cnt_hi_reg + 8'h01;
  wire cap_ev = lfo_fall & ctrl_reg[`ARTS_CTRL_CAP_EN] & gie_reg; // RQ12
  logic [7:0] cnt_lo_next;
  logic [7:0] cnt_hi_next;
  logic ovf_lo;
  logic ovf_hi;

  // overflow reloads; bus writes applied last so they win
  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    ovf_lo = 1'b0;
    ovf_hi = 1'b0;
    unique case (mode)
      arts_pkg::ARTS_MODE16: begin
        if (tick_lo & run) begin // RQ6
          ovf_lo = (cnt_lo_reg == 8'hff); // RQ9
          if (cnt16 == 16'hffff) begin
            cnt_lo_next = rl_lo_reg; // RQ2
            cnt_hi_next = rl_hi_reg;
            ovf_hi = 1'b1;
          end else begin
            cnt_lo_next = cnt16_inc[7:0];
            cnt_hi_next = cnt16_inc[15:8];
          end
        end
      end
      arts_pkg::ARTS_SPLIT: begin
        // low byte ignores run in split mode
        if (tick_lo) begin
          ovf_lo = (cnt_lo_reg == 8'hff); // RQ9
          cnt_lo_next = ovf_lo ? rl_lo_reg : lo_inc; // RQ5
        end
        if (tick_hi & run) begin // RQ6
          ovf_hi = (cnt_hi_reg == 8'hff);
          cnt_hi_next = ovf_hi ? rl_hi_reg : hi_inc; // RQ5
        end
      end
    endcase
    if (wr_cnt_lo) begin
      cnt_lo_next = w_data_reg; // RQ18
    end
    if (wr_cnt_hi) begin
      cnt_hi_next = w_data_reg; // RQ18
    end
  end

  // ****************************************************************
  // flags and interrupt
  // ****************************************************************
  // hardware sets win over any clear in the same cycle; nothing else clears
  wire hi_flag_keep = wr_ctrl ? w_data_reg[`ARTS_CTRL_HI_FLAG] :
                      (hi_flag_reg & ~(wr_stat & w_data_reg[`ARTS_ST_HI]));
  wire lo_flag_keep = wr_ctrl ? w_data_reg[`ARTS_CTRL_LO_FLAG] :
                      (lo_flag_reg & ~(wr_stat & w_data_reg[`ARTS_ST_LO]));
  wire hi_flag_next = ovf_hi | hi_flag_keep; // RQ11
  wire lo_flag_next = ovf_lo | lo_flag_keep; // RQ11
  wire cap_flag_next = cap_ev | (cap_flag_reg & ~(wr_stat & w_data_reg[`ARTS_ST_CAP]));
  wire lo_irq_en = ctrl_reg[`ARTS_CTRL_LO_IRQ_EN];
  wire irq_hi = hi_flag_reg & mask_reg[`ARTS_ST_HI]; // RQ3 RQ10
  wire irq_lo = lo_flag_reg & lo_irq_en & mask_reg[`ARTS_ST_LO]; // RQ4 RQ10
  wire irq_cap = cap_flag_reg & mask_reg[`ARTS_ST_CAP]; // RQ12
  wire irq_next = gie_reg & (irq_hi | irq_lo | irq_cap); // RQ17

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [7:0] ctrl_rd = {hi_flag_reg, lo_flag_reg, ctrl_reg[5:2], 1'b0,
                        ctrl_reg[0]}; // RQ13
  logic [7:0] rd_byte;
  logic rd_hit;

  // the low count is one register in both modes, so it reads as is
  always_comb begin
    rd_byte = `ARTS_RST_BYTE;
    rd_hit = 1'b1;
    unique case (rd_idx)
      `ARTS_IDX_CTRL: rd_byte = ctrl_rd;
      `ARTS_IDX_RL_LO: rd_byte = rl_lo_reg;
      `ARTS_IDX_RL_HI: rd_byte = rl_hi_reg;
      `ARTS_IDX_CNT_LO: rd_byte = cnt_lo_reg; // RQ14
      `ARTS_IDX_CNT_HI: rd_byte = cnt_hi_reg;
      `ARTS_IDX_CLKCTL: rd_byte = {2'b00, clkctl_reg, 4'h0};
      `ARTS_IDX_GIE: rd_byte = {2'b00, gie_reg, 5'h00};
      `ARTS_IDX_STAT: rd_byte = {5'h00, cap_flag_reg, lo_flag_reg, hi_flag_reg};
      `ARTS_IDX_MASK: rd_byte = {5'h00, mask_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // bus handshake next values
  // ****************************************************************
  wire aw_full_next = wr_do ? 1'b0 : (aw_full_reg | aw_take);
  wire w_full_next = wr_do ? 1'b0 : (w_full_reg | w_take);
  wire bvalid_next = wr_do | (bvalid_reg & ~i_bready);
  wire rvalid_next = ar_take | (rvalid_reg & ~i_rready);

  // ****************************************************************
  // pin synchronisers and dividers
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      lfo_s1_reg <= 1'b0;
      lfo_s2_reg <= 1'b0;
      lfo_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= i_ext_clk; // RQ8
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      lfo_s1_reg <= i_lfo_clk;
      lfo_s2_reg <= lfo_s1_reg;
      lfo_s3_reg <= lfo_s2_reg;
    end
  end

  // free-running prescalers, so a selected source never waits to start
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      div_sys_reg <= 4'h0;
      div_ext_reg <= 3'h0;
    end else begin
      div_sys_reg <= tick_sys12 ? 4'h0 : div_sys_reg + 4'h1;
      if (ext_rise) begin
        div_ext_reg <= div_ext_reg + 3'h1;
      end
    end
  end

  // ****************************************************************
  // timer registers
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_lo_reg <= `ARTS_RST_BYTE;
      cnt_hi_reg <= `ARTS_RST_BYTE;
      hi_flag_reg <= 1'b0;
      lo_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      hi_flag_reg <= hi_flag_next;
      lo_flag_reg <= lo_flag_next;
      cap_flag_reg <= cap_flag_next;
      irq_reg <= irq_next;
    end
  end

  // capture takes the reload bytes over a same-cycle bus write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rl_lo_reg <= `ARTS_RST_BYTE;
      rl_hi_reg <= `ARTS_RST_BYTE;
    end else if (cap_ev) begin
      rl_lo_reg <= cnt_lo_reg; // RQ12
      rl_hi_reg <= cnt_hi_reg;
    end else begin
      rl_lo_reg <= wr_rl_lo ? w_data_reg : rl_lo_reg;
      rl_hi_reg <= wr_rl_hi ? w_data_reg : rl_hi_reg;
    end
  end

  // software configuration; bit 1 is never stored
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= `ARTS_RST_BYTE;
      clkctl_reg <= 2'b00;
      gie_reg <= 1'b0;
      mask_reg <= `ARTS_RST_MASK;
    end else begin
      ctrl_reg <= wr_ctrl ? {2'b00, w_data_reg[5:2], 1'b0, w_data_reg[0]} : ctrl_reg;
      clkctl_reg <= wr_clkctl ? w_data_reg[5:4] : clkctl_reg;
      gie_reg <= wr_gie ? w_data_reg[`ARTS_GIE_TIMER] : gie_reg;
      mask_reg <= wr_mask ? w_data_reg[2:0] : mask_reg;
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ARTS_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_take) begin
        aw_addr_reg <= i_awaddr;
      end
      if (w_take) begin
        w_data_reg <= i_wdata[7:0];
        w_strb_reg <= i_wstrb[0];
      end
      // one write in flight: readies stay low until the response is taken
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg <= ~w_full_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      if (wr_do) begin
        bresp_reg <= wr_mapped ? `ARTS_RESP_OKAY : `ARTS_RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `ARTS_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_hit ? `ARTS_RESP_OKAY : `ARTS_RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_irq = irq_reg;

endmodule // arts_timer

// file: logic/arts_defs.svh
// constants for the split-mode auto-reload timer: register indices, field
// positions, reset values and divider ratios.
// assumes inclusion by bare name from the timer module and the bench.
`ifndef ARTS_DEFS_SVH
`define ARTS_DEFS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define ARTS_IDX_CTRL 10'h0c8
`define ARTS_IDX_RL_LO 10'h0ca
`define ARTS_IDX_RL_HI 10'h0cb
`define ARTS_IDX_CNT_LO 10'h0cc
`define ARTS_IDX_CNT_HI 10'h0cd
`define ARTS_IDX_CLKCTL 10'h08f
`define ARTS_IDX_GIE 10'h0a8
`define ARTS_IDX_STAT 10'h0e0
`define ARTS_IDX_MASK 10'h0e1

// ****************************************************************
// control register fields
// ****************************************************************
`define ARTS_CTRL_HI_FLAG 7
`define ARTS_CTRL_LO_FLAG 6
`define ARTS_CTRL_LO_IRQ_EN 5
`define ARTS_CTRL_CAP_EN 4
`define ARTS_CTRL_SPLIT 3
`define ARTS_CTRL_RUN 2
`define ARTS_CTRL_EXT_SEL 0

// ****************************************************************
// other fields
// ****************************************************************
`define ARTS_CLK_LO_SEL 4
`define ARTS_CLK_HI_SEL 5
`define ARTS_GIE_TIMER 5
`define ARTS_ST_HI 0
`define ARTS_ST_LO 1
`define ARTS_ST_CAP 2

// ****************************************************************
// reset values, dividers and response codes
// ****************************************************************
`define ARTS_RST_BYTE 8'h00
`define ARTS_RST_MASK 3'h7
`define ARTS_DIV_SYS 4'hb
`define ARTS_DIV_EXT 3'h7
`define ARTS_RESP_OKAY 2'h0
`define ARTS_RESP_SLVERR 2'h2

`endif

// file: logic/arts_pkg.sv
// types shared by the split-mode auto-reload timer.
// assumes nothing beyond the constants header.
package arts_pkg;

  // counting mode, one-hot
  typedef enum logic [1:0] {
    ARTS_MODE16 = 2'b01,
    ARTS_SPLIT = 2'b10
  } arts_mode_t;

endpackage

// file: sim/arts_timer_props.sv
// checker for the bus handshakes and the interrupt level of the timer.
// assumes it is bound to arts_timer and sees only that module's ports.
`timescale 1ns/1ps
module arts_timer_props (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // write channels
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  // read channels
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  // interrupt
  input wire logic o_irq
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // address and data taken at one edge
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_take;
    i_arvalid && o_arready;
  endsequence
  // response is raised at the same edge that the update lands
  a_write_answer: assert property (s_wr_take |=> !o_bvalid ##1 o_bvalid)
    else $error("write response not two cycles after the take");
  a_bresp_held: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response changed before bready");
  a_wr_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write ready high while a response waits");
  // readies come back at the very edge that takes the response
  a_wr_reopen: assert property (o_bvalid && i_bready |=> o_awready && o_wready)
    else $error("write ready not back after the response");
  a_read_answer: assert property (s_rd_take |=> o_rvalid)
    else $error("read data not one cycle after the take");
  a_rdata_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed before rready");
  a_rd_refused: assert property (o_rvalid |-> !o_arready && o_rdata[31:8] == 24'h00_0000)
    else $error("read ready high or upper data set during a read");
  // only a register write may lower the interrupt; hardware never clears a flag
  a_irq_sticky: assert property ($fell(o_irq) && $past(i_rst_n) |-> $past(o_bvalid))
    else $error("interrupt dropped without a register write");
endmodule // arts_timer_props
bind arts_timer arts_timer_props u_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_rdata(o_rdata), .o_irq(o_irq)
);

// file: sim/tb_arts_timer.sv
// self-checking bench for the split-mode timer: axi4-lite master, result
// queues read by a monitor, and a watchdog.
// assumes the constants header, the timer and its bound checker are compiled.
`timescale 1ns/1ps
`include "arts_defs.svh"
module tb_arts_timer;
  // ********
  // signals and instance
  // ********
  logic clk = 1'h0, rst_n = 1'h0, ext_clk = 1'h0, lfo = 1'h1, ext_on = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$], bq[$];
  logic [7:0] v, u;
  int num_errors = 0, n_compared = 0, seed = 39;
  logic [9:0] idx_tab [9] = '{`ARTS_IDX_CTRL, `ARTS_IDX_RL_LO, `ARTS_IDX_RL_HI,
    `ARTS_IDX_CNT_LO, `ARTS_IDX_CNT_HI, `ARTS_IDX_CLKCTL, `ARTS_IDX_GIE,
    `ARTS_IDX_STAT, `ARTS_IDX_MASK};
  arts_timer dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_ext_clk(ext_clk), .i_lfo_clk(lfo),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .o_irq(irq)
  );
  // 250 mhz system clock
  initial begin
    forever #2 clk = ~clk;
  end
  // irregular external source, only inside a test window
  always @(posedge clk) begin
    if (ext_on && ($random(seed) % 3 == 0)) ext_clk <= ~ext_clk;
  end
  // results are matched to the oldest note, in order of appearance
  always @(posedge clk) begin
    if (rvalid === 1'h1 && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'h1 && bready) chk("bresp", bq.pop_front(), 34'(bresp));
  end
  // ********
  // tasks
  // ********
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic see_irq(input logic e, input int n);
    repeat (n) @(posedge clk);
    chk("irq", 34'(e), 34'(irq));
  endtask
  // always lets one edge pass so callers never drive twice in one step
  task automatic wait_irq(input int n);
    repeat (n) begin
      @(posedge clk);
      if (irq === 1'h1) break;
    end
  endtask
  // one write; bready comes at random once bvalid is seen
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    bq.push_back(34'(er));
    awaddr <= {idx, 2'h0};
    wdata <= 32'(d);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && !bready) bready <= 1'($random(seed));
    end while (!(bvalid && bready));
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    rq.push_back({er, 32'(d)});
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && !rready) rready <= 1'($random(seed));
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask
  // load a mode, wait for its overflow, check flags and high byte, then stop
  task automatic run_case(input logic [7:0] ctl, ck, lo, hi, e_ctl, e_hi, input int quiet);
    wr(`ARTS_IDX_CLKCTL, ck);
    wr(`ARTS_IDX_CNT_LO, lo);
    wr(`ARTS_IDX_CNT_HI, hi);
    wr(`ARTS_IDX_CTRL, ctl);
    see_irq(1'h0, quiet);
    ext_on <= 1'h1;
    wait_irq(600);
    ext_on <= 1'h0;
    see_irq(1'h1, 0);
    rd(`ARTS_IDX_CTRL, e_ctl);
    rd(`ARTS_IDX_CNT_HI, e_hi);
    wr(`ARTS_IDX_CTRL, 8'h00);
    see_irq(1'h0, 2);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********
  // sequence and watchdog
  // ********
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    foreach (idx_tab[i]) rd(idx_tab[i], (i == 8) ? 8'h07 : 8'h00);
    rd(10'h3ff, 8'h00, 2'h2);
    wr(10'h3ff, 8'h55, 2'h2);
    wr(`ARTS_IDX_CTRL, 8'h02);
    rd(`ARTS_IDX_CTRL, 8'h00);
    v = 8'($random(seed));
    wr(`ARTS_IDX_RL_LO, v);
    rd(`ARTS_IDX_RL_LO, v);
    wr(`ARTS_IDX_CNT_LO, ~v);
    rd(`ARTS_IDX_CNT_LO, ~v);
    wr(`ARTS_IDX_RL_LO, 8'h00);
    wr(`ARTS_IDX_RL_HI, 8'h12);
    wr(`ARTS_IDX_GIE, 8'h20);
    run_case(8'h04, 8'h10, 8'hf0, 8'hff, 8'hc4, 8'h12, 0);
    run_case(8'h24, 8'h20, 8'hfd, 8'h00, 8'h64, 8'h01, 8);
    run_case(8'h05, 8'h00, 8'hff, 8'hff, 8'hc5, 8'h12, 40);
    run_case(8'h28, 8'h10, 8'hf0, 8'h77, 8'h68, 8'h77, 0);
    run_case(8'h0d, 8'h00, 8'h00, 8'hff, 8'h8d, 8'h12, 40);
    u = 8'($random(seed));
    wr(`ARTS_IDX_CNT_LO, v);
    wr(`ARTS_IDX_CNT_HI, u);
    wr(`ARTS_IDX_CTRL, 8'h10);
    lfo <= 1'h0;
    wait_irq(50);
    see_irq(1'h1, 0);
    rd(`ARTS_IDX_RL_LO, v);
    rd(`ARTS_IDX_RL_HI, u);
    rd(`ARTS_IDX_STAT, 8'h04);
    wr(`ARTS_IDX_MASK, 8'h03);
    see_irq(1'h0, 2);
    wr(`ARTS_IDX_MASK, 8'h07);
    see_irq(1'h1, 2);
    wr(`ARTS_IDX_STAT, 8'h04);
    see_irq(1'h0, 2);
    finish_test();
  end
  // the sequence needs a few hundred cycles; this allows about fifty thousand
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule // tb_arts_timer
